/* File: core/scr_section2_regs.sv */
// section 2 spare registers and crc reference, apb slave with crc self check
//
// Behaviour
// - spare fields read back, affect nothing but the section 2 crc
// - spares feed the section 2 crc
// - two full spare words, one spare upper byte
// - 16-bit crc reference, reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "scr_map.svh"

module scr_section2_regs
	import scr_pkg::*;
#(
	parameter int          AW   = 12,
	parameter logic [15:0] POLY = `SCR_CRC_POLY,
	parameter logic [15:0] INIT = `SCR_CRC_INIT
)
(
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	output logic      [15:0]   crc_reference_value,
	output logic      [15:0]   crc_computed_value,
	output logic               crc_mismatch
);

	// stored register contents, only writable bits are ever set
	scr_word_t mixed_a_q;   // spare bits 11:10 and 5:4
	scr_word_t full_b_q;    // all 16 bits spare
	scr_word_t upper_q;     // spare upper byte
	scr_word_t full_d_q;    // all 16 bits spare
	scr_word_t ref_q;       // section 2 crc reference value

	// crc bookkeeping
	logic      start_q;     // recompute request to the engine
	logic      init_q;      // first check after reset still pending
	logic      have_crc_q;  // a computed crc exists
	scr_word_t calc_q;      // last computed crc
	logic      mism_q;      // computed differs from reference

	// bus answer registers
	logic        ready_q;   // access phase answered
	logic        err_q;     // unmapped address
	logic [31:0] rdata_q;   // read data held for the answer

	scr_crc_if crc_link ();

	// merge a write into a register: byte lanes first, then writable mask
	function automatic scr_word_t wr_merge
	(
		input scr_word_t   old_v,
		input logic [31:0] wdata,
		input logic [3:0]  strb,
		input scr_word_t   wmask
	);
		scr_word_t lane;
		lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		wr_merge = (old_v & ~lane) | (wdata[15:0] & lane);
	endfunction

	// byte address of a register index
	function automatic logic [AW-1:0] byte_addr
	(
		input logic [7:0] idx
	);
		byte_addr = AW'({idx, 2'b00});
	endfunction

	// address decode
	scr_sel_t sel;
	logic     hit_mixed;
	logic     hit_full_b;
	logic     hit_upper;
	logic     hit_full_d;
	logic     hit_ref;
	logic     hit_status;

	assign hit_mixed  = (paddr == byte_addr(`SCR_IDX_SPARE_MIXED_A));
	assign hit_full_b = (paddr == byte_addr(`SCR_IDX_SPARE_FULL_B));
	assign hit_upper  = (paddr == byte_addr(`SCR_IDX_SPARE_UPPER_BYTE));
	assign hit_full_d = (paddr == byte_addr(`SCR_IDX_SPARE_FULL_D));
	assign hit_ref    = (paddr == byte_addr(`SCR_IDX_CRC_REFERENCE));
	assign hit_status = (paddr == byte_addr(`SCR_IDX_CRC_STATUS));

	assign sel = hit_mixed  ? SCR_SEL_MIXED  :
	             hit_full_b ? SCR_SEL_FULL_B :
	             hit_upper  ? SCR_SEL_UPPER  :
	             hit_full_d ? SCR_SEL_FULL_D :
	             hit_ref    ? SCR_SEL_REF    :
	             hit_status ? SCR_SEL_STATUS : SCR_SEL_NONE;

	// the access phase waits one cycle, then answers; the write commits on that edge
	logic access;       // access phase, not yet answered
	logic commit;       // edge at which the master samples pready high
	logic wr_commit;    // write takes effect
	logic spare_wr;     // write to a protected spare register

	assign access    = psel & penable & ~ready_q;
	assign commit    = psel & penable & ready_q;
	assign wr_commit = commit & pwrite & ~err_q;
	assign spare_wr  = wr_commit & ((sel == SCR_SEL_MIXED) | (sel == SCR_SEL_FULL_B) |
	                   (sel == SCR_SEL_UPPER) | (sel == SCR_SEL_FULL_D));

	// read views: reserved bits show their fixed pattern
	scr_word_t view_mixed;
	scr_word_t view_upper;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign view_mixed = (mixed_a_q & `SCR_WMASK_SPARE_MIXED_A) |
	                    `SCR_FIXED_SPARE_MIXED_A;
	assign view_upper = (upper_q & `SCR_WMASK_SPARE_UPPER_BYTE) |
	                    `SCR_FIXED_SPARE_UPPER_BYTE;

	assign status_word = {13'h0000, have_crc_q, crc_link.busy, mism_q, calc_q};

	// read multiplexer, unmapped reads return zero
	always_comb
	begin
		case (sel)
			SCR_SEL_MIXED:  rd_mux = {16'h0000, view_mixed};
			SCR_SEL_FULL_B: rd_mux = {16'h0000, full_b_q};
			SCR_SEL_UPPER:  rd_mux = {16'h0000, view_upper};
			SCR_SEL_FULL_D: rd_mux = {16'h0000, full_d_q};
			SCR_SEL_REF:    rd_mux = {16'h0000, ref_q};
			SCR_SEL_STATUS: rd_mux = status_word;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	// apb answer: one wait state, error flag for unmapped addresses
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ready_q <= access;
			err_q   <= access & (sel == SCR_SEL_NONE);
			if (access && !pwrite)
				rdata_q <= rd_mux;
		end
	end

	// spare registers: stored value only, read by the bus and by the crc image
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			mixed_a_q <= `SCR_RST_SPARE_MIXED_A & `SCR_WMASK_SPARE_MIXED_A;
			full_b_q  <= `SCR_RST_SPARE_FULL_B;
			upper_q   <= `SCR_RST_SPARE_UPPER_BYTE;
			full_d_q  <= `SCR_RST_SPARE_FULL_D;
		end
		else if (wr_commit)
		begin
			// masked merge drops any write to reserved bits
			if (sel == SCR_SEL_MIXED)
				mixed_a_q <= wr_merge(mixed_a_q, pwdata, pstrb,
				                      `SCR_WMASK_SPARE_MIXED_A);
			if (sel == SCR_SEL_FULL_B)
				full_b_q <= wr_merge(full_b_q, pwdata, pstrb,
				                     `SCR_WMASK_SPARE_FULL_B);
			if (sel == SCR_SEL_UPPER)
				upper_q <= wr_merge(upper_q, pwdata, pstrb,
				                    `SCR_WMASK_SPARE_UPPER_BYTE);
			if (sel == SCR_SEL_FULL_D)
				full_d_q <= wr_merge(full_d_q, pwdata, pstrb,
				                     `SCR_WMASK_SPARE_FULL_D);
		end
	end

	// crc reference, steers the mismatch compare
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			ref_q <= `SCR_RST_CRC_REFERENCE;
		else if (wr_commit && sel == SCR_SEL_REF)
			ref_q <= wr_merge(ref_q, pwdata, pstrb, `SCR_WMASK_CRC_REFERENCE);
	end

	// the image is the read view of the spares, so reserved patterns are covered too
	assign crc_link.image = {view_mixed, full_b_q, view_upper, full_d_q};
	assign crc_link.start = start_q;

	// recompute after reset and after every spare write; the engine restarts
	// on a new request, so the stored result always matches the latest content
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			init_q  <= 1'b1;
			start_q <= 1'b0;
		end
		else
		begin
			init_q  <= 1'b0;
			start_q <= init_q | spare_wr;
		end
	end

	// capture the engine result and compare with the reference
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			have_crc_q <= 1'b0;
			calc_q     <= 16'h0000;
			mism_q     <= 1'b0;
		end
		else
		begin
			if (crc_link.valid)
			begin
				calc_q     <= crc_link.result;
				have_crc_q <= 1'b1;
			end
			else if (start_q)
				have_crc_q <= 1'b0;
			// mismatch only reported once a result exists
			mism_q <= have_crc_q & (calc_q != ref_q);
		end
	end

	// serial crc engine
	scr_crc_engine #(
		.POLY (POLY),
		.INIT (INIT)
	) u_engine (
		.clk   (clk),
		.rst_b (rst_b),
		.crc   (crc_link)
	);

	// outputs straight from flops
	assign prdata              = rdata_q;
	assign pready              = ready_q;
	assign pslverr             = err_q;
	assign crc_reference_value = ref_q;
	assign crc_computed_value  = calc_q;
	assign crc_mismatch        = mism_q;

endmodule

`default_nettype wire

/* File: shared/scr_map.svh */
// register offsets, field masks, reset values and crc constants of the section 2 spare bank
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// register indices; the byte address on apb is four times the index
`define SCR_IDX_SPARE_MIXED_A    8'hA0
`define SCR_IDX_SPARE_FULL_B     8'hA1
`define SCR_IDX_SPARE_UPPER_BYTE 8'hA2
`define SCR_IDX_SPARE_FULL_D     8'hA3
`define SCR_IDX_CRC_REFERENCE    8'hBE
`define SCR_IDX_CRC_STATUS       8'hBF

// writable bits of each register; everything else is reserved
`define SCR_WMASK_SPARE_MIXED_A    16'h0C30
`define SCR_WMASK_SPARE_FULL_B     16'hFFFF
`define SCR_WMASK_SPARE_UPPER_BYTE 16'hFF00
`define SCR_WMASK_SPARE_FULL_D     16'hFFFF
`define SCR_WMASK_CRC_REFERENCE    16'hFFFF

// fixed pattern of reserved bits, returned on every read
`define SCR_FIXED_SPARE_MIXED_A    16'h0200
`define SCR_FIXED_SPARE_UPPER_BYTE 16'h0000

// reset values of the registers
`define SCR_RST_SPARE_MIXED_A    16'h0210
`define SCR_RST_SPARE_FULL_B     16'h0000
`define SCR_RST_SPARE_UPPER_BYTE 16'h0000
`define SCR_RST_SPARE_FULL_D     16'h0000
`define SCR_RST_CRC_REFERENCE    16'h0000

// status register field positions
`define SCR_STAT_MISMATCH_BIT 16
`define SCR_STAT_BUSY_BIT     17
`define SCR_STAT_VALID_BIT    18

// crc engine defaults and image length in bits
`define SCR_CRC_POLY      16'h1021
`define SCR_CRC_INIT      16'hFFFF
`define SCR_CRC_IMAGE_LEN 7'h40

`endif

/* File: shared/scr_pkg.sv */
// types shared by the section 2 spare bank and its crc engine
package scr_pkg;

	// one 16-bit register word
	typedef logic [15:0] scr_word_t;

	// protected image: four spare registers, first register in the top bits
	typedef logic [63:0] scr_image_t;

	// register selected by the current apb address
	typedef enum logic [2:0]
	{
		SCR_SEL_NONE   = 3'b000,
		SCR_SEL_MIXED  = 3'b001,
		SCR_SEL_FULL_B = 3'b010,
		SCR_SEL_UPPER  = 3'b011,
		SCR_SEL_FULL_D = 3'b100,
		SCR_SEL_REF    = 3'b101,
		SCR_SEL_STATUS = 3'b110
	} scr_sel_t;

	// crc engine states
	typedef enum logic [1:0]
	{
		SCR_ENG_IDLE  = 2'b00,
		SCR_ENG_SHIFT = 2'b01,
		SCR_ENG_DONE  = 2'b10
	} scr_eng_state_t;

endpackage

/* File: shared/scr_crc_if.sv */
// link between the register bank and its serial crc engine
`timescale 1ns/1ps
`default_nettype none

interface scr_crc_if;
	import scr_pkg::*;

	logic       start;   // one-cycle request to recompute
	scr_image_t image;   // protected content, sampled with start
	logic       busy;    // engine is shifting
	logic       valid;   // one-cycle pulse, result is fresh
	scr_word_t  result;  // last computed crc

	modport ctl
	(
		output start,
		output image,
		input  busy,
		input  valid,
		input  result
	);

	modport eng
	(
		input  start,
		input  image,
		output busy,
		output valid,
		output result
	);
endinterface

`default_nettype wire

/* File: core/scr_crc_engine.sv */
// serial crc over the protected spare image, one bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "scr_map.svh"

module scr_crc_engine
	import scr_pkg::*;
#(
	parameter logic [15:0] POLY = `SCR_CRC_POLY,
	parameter logic [15:0] INIT = `SCR_CRC_INIT
)
(
	input  wire logic clk,
	input  wire logic rst_b,
	scr_crc_if.eng    crc
);

	scr_eng_state_t state_q;   // engine state
	scr_eng_state_t state_d;
	scr_image_t     img_q;     // snapshot, shifted msb first
	logic [6:0]     cnt_q;     // bits already taken
	scr_word_t      crc_q;     // running remainder
	scr_word_t      crc_d;
	logic           fb;        // feedback bit
	logic           last_bit;  // final bit of the image

	assign fb       = crc_q[15] ^ img_q[63];
	assign crc_d    = {crc_q[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
	assign last_bit = (cnt_q == (`SCR_CRC_IMAGE_LEN - 7'h01));

	// next state; a new start always restarts, so a late write is never missed
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			SCR_ENG_IDLE:  state_d = crc.start ? SCR_ENG_SHIFT : SCR_ENG_IDLE;
			SCR_ENG_SHIFT: state_d = crc.start ? SCR_ENG_SHIFT :
				(last_bit ? SCR_ENG_DONE : SCR_ENG_SHIFT);
			SCR_ENG_DONE:  state_d = crc.start ? SCR_ENG_SHIFT : SCR_ENG_IDLE;
			default:       state_d = SCR_ENG_IDLE;
		endcase
	end

	// state, counter and shift register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_q <= SCR_ENG_IDLE;
			img_q   <= 64'h0000_0000_0000_0000;
			cnt_q   <= 7'h00;
			crc_q   <= INIT;
		end
		else
		begin
			state_q <= state_d;
			if (crc.start)
			begin
				img_q <= crc.image;
				cnt_q <= 7'h00;
				crc_q <= INIT;
			end
			else if (state_q == SCR_ENG_SHIFT)
			begin
				img_q <= {img_q[62:0], 1'b0};
				cnt_q <= cnt_q + 7'h01;
				crc_q <= crc_d;
			end
		end
	end

	// result and flags, all registered
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			crc.result <= 16'h0000;
			crc.valid  <= 1'b0;
			crc.busy   <= 1'b0;
		end
		else
		begin
			crc.valid <= (state_d == SCR_ENG_DONE);
			crc.busy  <= (state_d == SCR_ENG_SHIFT);
			if (state_q == SCR_ENG_SHIFT && last_bit && !crc.start)
				crc.result <= crc_d;
		end
	end

endmodule

`default_nettype wire

/* File: verification/scr_section2_regs_monitor.sv */
// concurrent checks on the ports of the section 2 spare register bank
`timescale 1ns/1ps
`default_nettype none

module scr_section2_regs_monitor
#(
	parameter int AW = 12
)
(
	input wire logic          clk,
	input wire logic          rst_b,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [3:0]    pstrb,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire logic [15:0]   crc_reference_value,
	input wire logic [15:0]   crc_computed_value,
	input wire logic          crc_mismatch
);
	// finished transfers; the bank decodes only the low twelve bits
	wire logic        xf_end = psel && penable && pready;
	wire logic        rd_end = xf_end && !pwrite;
	wire logic        wr_end = xf_end && pwrite;
	wire logic [11:0] a      = paddr[11:0];
	wire logic        ref_wr = wr_end && (a == 12'h2F8);   // write to the crc reference

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// setup cycle followed by the first access cycle
	sequence s_enter;
		psel && !penable ##1 psel && penable;
	endsequence

	AST_WAIT_STATE: assert property (s_enter |-> !pready ##1 pready)
		else $error("ready not one cycle after first access");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> xf_end)
		else $error("error outside a finished transfer");
	AST_RESET_CLEAR: assert property ($rose(rst_b) |-> !crc_reference_value && !pready)
		else $error("reference or ready not clear after reset");
	// reset clears the reference too, so the cycle after reset is excused
	AST_REF_BY_WRITE: assert property (!$stable(crc_reference_value) |->
		$past(ref_wr) || !$past(rst_b))
		else $error("reference changed without a write");
	AST_MISMATCH_CAUSE: assert property (crc_mismatch |->
		$past(crc_computed_value) != $past(crc_reference_value))
		else $error("mismatch while values agree");
	// a full spare word rewrite must reach the crc within one computation
	AST_SPARE_RECOMPUTE: assert property (wr_end && a == 12'h284 && pstrb == 4'hF
		|-> ##[2:120] $changed(crc_computed_value))
		else $error("spare write did not change the crc");
	AST_A0_RESERVED: assert property (rd_end && a == 12'h280 |->
		prdata[15:12] == 4'h0 && prdata[9:6] == 4'h8 && prdata[3:0] == 4'h0)
		else $error("reserved bits of the mixed register wrong");
	AST_UPPER_ZERO: assert property (rd_end && a != 12'h2FC |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
endmodule

`default_nettype wire

/* File: verification/tb_scr_section2_regs.sv */
// self-checking bench for the section 2 spare register bank
`timescale 1ns/1ps
`default_nettype none

module tb_scr_section2_regs;
	logic        clk         = 1'b0;
	logic        rst_b       = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [11:0] paddr       = 12'h000;
	logic [31:0] pwdata      = 32'h0000_0000;
	logic [3:0]  pstrb       = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] crc_reference_value;
	logic [15:0] crc_computed_value;
	logic        crc_mismatch;
	int          err_count   = 0;
	int          checks_done = 0;
	logic [31:0] rd_v;
	logic        er_v;
	logic [15:0] snap;
	logic [63:0] img;   // expected protected image, first register on top
	// register table: address, writable bits, fixed bits, reset value
	logic [11:0] addr_t [5] = '{12'h280, 12'h284, 12'h288, 12'h28C, 12'h2F8};
	logic [15:0] mask_t [5] = '{16'h0C30, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFFFF};
	logic [15:0] fix_t  [5] = '{16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [15:0] rst_t  [5] = '{16'h0210, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	// each pattern changes the full spare word, so the crc must move
	logic [31:0] pat_t  [3] = '{32'hFFFF_FFFF, 32'h0000_5AA5, 32'h0000_C3C3};

	scr_section2_regs #(.AW(12)) u_scr_section2_regs
	(
		.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .crc_reference_value, .crc_computed_value,
		.crc_mismatch
	);

	// free-running 100 MHz clock
	always #5 clk = ~clk;

	// one apb transfer, held until ready is sampled high
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			err_count++;
		rd_v = prdata;
		er_v = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// independent crc: poly 0x1021, init 0xFFFF, msb first, no final xor
	function automatic logic [15:0] crc_model(input logic [63:0] im);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int k = 63; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ im[k]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	// bounded wait for the computed crc to leave an old value
	task automatic wait_crc(input logic [15:0] old);
		int n;
		n = 0;
		while (crc_computed_value === old && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk({31'h0000_0000, n < 200}, 32'h0000_0001);
	endtask

	// counts, verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog, far beyond the expected run of under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		wait_crc(16'h0000);
		chk({16'h0000, crc_computed_value}, {16'h0000, crc_model(64'h0210_0000_0000_0000)});
		for (int i = 0; i < 5; i++)
		begin
			xfer(addr_t[i], 1'b0, 32'h0000_0000, 4'h0);
			chk(rd_v, {16'h0000, rst_t[i]});
		end
		foreach (pat_t[p])
		begin
			snap = crc_computed_value;
			for (int i = 0; i < 5; i++)
				xfer(addr_t[i], 1'b1, pat_t[p], 4'hF);
			wait_crc(snap);
			img = {pat_t[p][15:0] & mask_t[0] | fix_t[0], pat_t[p][15:0],
			       pat_t[p][15:0] & mask_t[2] | fix_t[2], pat_t[p][15:0]};
			chk({16'h0000, crc_computed_value}, {16'h0000, crc_model(img)});
			for (int i = 0; i < 5; i++)
			begin
				xfer(addr_t[i], 1'b0, 32'h0000_0000, 4'h0);
				chk(rd_v, {16'h0000, pat_t[p][15:0] & mask_t[i] | fix_t[i]});
			end
		end
		// low byte lane only: upper byte keeps its value
		xfer(12'h28C, 1'b1, 32'h0000_1234, 4'h1);
		xfer(12'h28C, 1'b0, 32'h0000_0000, 4'h0);
		chk(rd_v, 32'h0000_C334);
		xfer(12'h290, 1'b1, 32'h0000_FFFF, 4'hF);
		chk({31'h0000_0000, er_v}, 32'h0000_0001);
		xfer(12'h290, 1'b0, 32'h0000_0000, 4'h0);
		chk({er_v, rd_v[30:0]}, 32'h8000_0000);
		repeat (80) @(posedge clk);
		snap = crc_computed_value;
		xfer(12'h2F8, 1'b1, {16'h0000, snap}, 4'h3);
		repeat (2) @(posedge clk);
		chk({15'h0000, crc_mismatch, crc_reference_value}, {16'h0000, snap});
		xfer(12'h2F8, 1'b1, {16'h0000, ~snap}, 4'h3);
		repeat (2) @(posedge clk);
		chk({15'h0000, crc_mismatch, crc_reference_value}, {16'h0001, ~snap});
		// status word is read only: a write is ignored without an error
		xfer(12'h2FC, 1'b1, 32'hFFFF_FFFF, 4'hF);
		chk({31'h0000_0000, er_v}, 32'h0000_0000);
		xfer(12'h2FC, 1'b0, 32'h0000_0000, 4'h0);
		chk(rd_v, {16'h0005, snap});
		wrap_up();
	end
endmodule

bind scr_section2_regs scr_section2_regs_monitor #(.AW(AW)) u_scr_section2_regs_monitor
(
	.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
	.pslverr, .crc_reference_value, .crc_computed_value, .crc_mismatch
);

`default_nettype wire
